// ### src/aab_bank.sv
// Purpose: Attribute bank of the actuator object with full-scale service.
// Assumes: One request per cycle; answer one cycle after acceptance.
// Notes: Limit compare is signed for both data types; the type codes do not change it.
//
// Function
// - Full-scale service takes one signed 16-bit argument, any value.
// - The received full-scale argument is reported by the full-scale attribute.
// - Successful full-scale reply carries no data.
// - Class revision is read-only, constant, between one and 65535.
// - Data type accepts integer or floating only, defaulting to integer.
// - Data type and units writes refused while executing.
// - Data type read-only while an active connection uses typed attributes.
// - Polled assembly three activation forces integer type once, on its rising edge; later writes may change it.
// - Units select engineering units from a table, default counts.
// - Writable override and read-only drive level attributes exist.
// - Override codes: normal, closed, open, hold, apply safe state.
// - Status byte: alarm high, alarm low, warn high, warn low; upper zero.
// - Alarm enable defaults off and gates alarm bits.
// - Warning enable defaults off and gates warning bits.
// - High alarm when level exceeds high alarm threshold, default max.
// - Low alarm when level below low alarm threshold, default min.
// - High warning when level exceeds high warning threshold, default max.
// - Low warning when level below low warning threshold, default min.
// - Safe state selects drive whenever not executing.
// - Safe codes: closed, open, hold last, use safe value.
// - Safe value defaults zero and is reported when selected.
`timescale 1ns/10ps
`default_nettype none
module aab_bank #(
    parameter logic [15:0] CLASS_REVISION = 16'h0001,
    parameter int UNIT_TABLE_SIZE = 2
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire aab_pkg::aab_req_t req,
    output logic rsp_valid,
    output aab_pkg::aab_rsp_t rsp,
    input wire logic executing,
    input wire logic io_active,
    input wire logic polled_asm3_active,
    input wire logic [15:0] control_level,
    output logic [15:0] drive_out,
    output logic [7:0] flags_out
);
    import aab_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stored attributes.
    logic [7:0] value_type_ff;
    logic [15:0] unit_sel_ff;
    aab_ovr_t override_ff;
    logic [7:0] alarm_en_ff;
    logic [7:0] warn_en_ff;
    logic [15:0] alarm_hi_ff;
    logic [15:0] alarm_lo_ff;
    logic [15:0] warn_hi_ff;
    logic [15:0] warn_lo_ff;
    aab_fb_t fallback_ff;
    logic [15:0] fallback_lvl_ff;
    logic [15:0] full_scale_ff;
    logic [15:0] drive_ff;
    logic [15:0] hold_ff;
    logic [7:0] flags_ff;
    logic rsp_valid_ff;
    aab_rsp_t rsp_ff;
    logic polled_prev_ff;

    logic is_set;
    logic is_get;
    logic is_fs;
    logic wr_ok;
    aab_status_t wr_status;
    logic [15:0] rd_data;
    logic rd_ok;
    logic [15:0] nxt_drive;
    logic alarm_above;
    logic alarm_below;
    logic warn_above;
    logic warn_below;
    logic force_int;

    function automatic logic unit_known(input logic [15:0] code);
        unit_known = (code == UNIT_COUNTS) || (code == UNIT_PERCENT);
    endfunction : unit_known

    function automatic logic [15:0] fallback_level(input aab_fb_t mode,
                                                   input logic [15:0] hold,
                                                   input logic [15:0] safe);
        case (mode)
            FB_CLOSED: fallback_level = LEVEL_ZERO;
            FB_OPEN: fallback_level = FULL_OPEN;
            FB_HOLD: fallback_level = hold;
            default: fallback_level = safe;
        endcase
    endfunction : fallback_level

    assign is_set = req_valid && (req.service == SVC_SET);
    assign is_get = req_valid && (req.service == SVC_GET);
    assign is_fs = req_valid && (req.service == SVC_FULL_SCALE);
    assign force_int = polled_asm3_active && !polled_prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Write validation.
    always_comb begin
        wr_status = ST_OK;
        if (req.attr == ATTR_VALUE_TYPE) begin
            if (executing) begin
                wr_status = ST_BAD_STATE;
            end else if (io_active) begin
                wr_status = ST_READ_ONLY;
            end else if ((req.data[7:0] != TYPE_INT) && (req.data[7:0] != TYPE_REAL)) begin
                wr_status = ST_BAD_VALUE;
            end
        end else if (req.attr == ATTR_UNIT_SEL) begin
            if (executing) begin
                wr_status = ST_BAD_STATE;
            end else if (!unit_known(req.data)) begin
                wr_status = ST_BAD_VALUE;
            end
        end else if (req.attr == ATTR_OVERRIDE) begin
            if (req.data > 16'h0004) begin
                wr_status = ST_BAD_VALUE;
            end
        end else if (req.attr == ATTR_FALLBACK) begin
            if (req.data > 16'h0003) begin
                wr_status = ST_BAD_VALUE;
            end
        end else if (req.attr == ATTR_ALARM_EN || req.attr == ATTR_WARN_EN) begin
            if (req.data > 16'h0001) begin
                wr_status = ST_BAD_VALUE;
            end
        end else if (req.attr == ATTR_CLASS_REV || req.attr == ATTR_DRIVE_LEVEL
                     || req.attr == ATTR_LIMIT_FLAGS || req.attr == ATTR_FULL_SCALE) begin
            wr_status = ST_READ_ONLY;
        end else if (req.attr != ATTR_ALARM_HI && req.attr != ATTR_ALARM_LO
                     && req.attr != ATTR_WARN_HI && req.attr != ATTR_WARN_LO
                     && req.attr != ATTR_FALLBACK_LVL) begin
            wr_status = ST_BAD_ATTR;
        end
    end
    assign wr_ok = is_set && (wr_status == ST_OK);

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer.
    always_comb begin
        rd_ok = 1'b1;
        rd_data = 16'h0000;
        if (req.attr == ATTR_CLASS_REV) begin
            rd_data = CLASS_REVISION;
        end else if (req.attr == ATTR_VALUE_TYPE) begin
            rd_data = {8'h00, value_type_ff};
        end else if (req.attr == ATTR_UNIT_SEL) begin
            rd_data = unit_sel_ff;
        end else if (req.attr == ATTR_OVERRIDE) begin
            rd_data = {13'h0000, override_ff};
        end else if (req.attr == ATTR_DRIVE_LEVEL) begin
            rd_data = drive_ff;
        end else if (req.attr == ATTR_LIMIT_FLAGS) begin
            rd_data = {8'h00, flags_ff};
        end else if (req.attr == ATTR_ALARM_EN) begin
            rd_data = {8'h00, alarm_en_ff};
        end else if (req.attr == ATTR_WARN_EN) begin
            rd_data = {8'h00, warn_en_ff};
        end else if (req.attr == ATTR_FULL_SCALE) begin
            rd_data = full_scale_ff;
        end else if (req.attr == ATTR_ALARM_HI) begin
            rd_data = alarm_hi_ff;
        end else if (req.attr == ATTR_ALARM_LO) begin
            rd_data = alarm_lo_ff;
        end else if (req.attr == ATTR_WARN_HI) begin
            rd_data = warn_hi_ff;
        end else if (req.attr == ATTR_WARN_LO) begin
            rd_data = warn_lo_ff;
        end else if (req.attr == ATTR_FALLBACK) begin
            rd_data = {14'h0000, fallback_ff};
        end else if (req.attr == ATTR_FALLBACK_LVL) begin
            rd_data = fallback_lvl_ff;
        end else begin
            rd_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration storage.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            value_type_ff <= TYPE_INT;
            unit_sel_ff <= UNIT_COUNTS;
        end else begin
            if (force_int) begin
                value_type_ff <= TYPE_INT;
            end else if (wr_ok && req.attr == ATTR_VALUE_TYPE) begin
                value_type_ff <= req.data[7:0];
            end
            if (wr_ok && req.attr == ATTR_UNIT_SEL) begin
                unit_sel_ff <= req.data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            override_ff <= OVR_NORMAL;
            fallback_ff <= FB_CLOSED;
            fallback_lvl_ff <= LEVEL_ZERO;
            alarm_en_ff <= ENABLE_RESET;
            warn_en_ff <= ENABLE_RESET;
        end else if (wr_ok) begin
            if (req.attr == ATTR_OVERRIDE) begin
                override_ff <= aab_ovr_t'(req.data[2:0]);
            end
            if (req.attr == ATTR_FALLBACK) begin
                fallback_ff <= aab_fb_t'(req.data[1:0]);
            end
            if (req.attr == ATTR_FALLBACK_LVL) begin
                fallback_lvl_ff <= req.data;
            end
            if (req.attr == ATTR_ALARM_EN) begin
                alarm_en_ff <= req.data[7:0];
            end
            if (req.attr == ATTR_WARN_EN) begin
                warn_en_ff <= req.data[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            alarm_hi_ff <= INT_MAX;
            alarm_lo_ff <= INT_MIN;
            warn_hi_ff <= INT_MAX;
            warn_lo_ff <= INT_MIN;
        end else if (wr_ok) begin
            if (req.attr == ATTR_ALARM_HI) begin
                alarm_hi_ff <= req.data;
            end
            if (req.attr == ATTR_ALARM_LO) begin
                alarm_lo_ff <= req.data;
            end
            if (req.attr == ATTR_WARN_HI) begin
                warn_hi_ff <= req.data;
            end
            if (req.attr == ATTR_WARN_LO) begin
                warn_lo_ff <= req.data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            full_scale_ff <= FULL_SCALE_RESET;
        end else if (is_fs) begin
            full_scale_ff <= req.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive selection; hold value tracks the drive while executing with normal override.
    always_comb begin
        if (!executing) begin
            nxt_drive = fallback_level(fallback_ff, hold_ff, fallback_lvl_ff);
        end else begin
            case (override_ff)
                OVR_CLOSED: nxt_drive = LEVEL_ZERO;
                OVR_OPEN: nxt_drive = FULL_OPEN;
                OVR_HOLD: nxt_drive = hold_ff;
                OVR_SAFE: nxt_drive = fallback_level(fallback_ff, hold_ff, fallback_lvl_ff);
                default: nxt_drive = control_level;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            drive_ff <= LEVEL_ZERO;
            hold_ff <= LEVEL_ZERO;
            polled_prev_ff <= 1'b0;
        end else begin
            drive_ff <= nxt_drive;
            polled_prev_ff <= polled_asm3_active;
            if (executing && override_ff == OVR_NORMAL) begin
                hold_ff <= nxt_drive;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limit flags.
    aab_limit_cmp u_alarm_cmp (
        .level(drive_ff),
        .upper(alarm_hi_ff),
        .lower(alarm_lo_ff),
        .enable(alarm_en_ff[0]),
        .above(alarm_above),
        .below(alarm_below)
    );

    aab_limit_cmp u_warn_cmp (
        .level(drive_ff),
        .upper(warn_hi_ff),
        .lower(warn_lo_ff),
        .enable(warn_en_ff[0]),
        .above(warn_above),
        .below(warn_below)
    );

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_ff <= 8'h00;
        end else begin
            flags_ff <= {4'h0, warn_below, warn_above, alarm_below, alarm_above};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer path.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            rsp_valid_ff <= req_valid;
            rsp_ff <= '0;
            if (is_get) begin
                rsp_ff.status <= rd_ok ? ST_OK : ST_BAD_ATTR;
                rsp_ff.has_data <= rd_ok;
                rsp_ff.data <= rd_ok ? rd_data : 16'h0000;
            end else if (is_set) begin
                rsp_ff.status <= wr_status;
            end else if (is_fs) begin
                rsp_ff.status <= ST_OK;
            end else if (req_valid) begin
                rsp_ff.status <= ST_BAD_SERVICE;
            end
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp = rsp_ff;
    assign drive_out = drive_ff;
    assign flags_out = flags_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_fs_req;
        is_fs;
    endsequence

    a_fs_report: assert property (@(posedge ref_clk) disable iff (reset)
        s_fs_req |=> full_scale_ff == $past(req.data))
        else $error("full scale not stored");
    a_fs_nodata: assert property (@(posedge ref_clk) disable iff (reset)
        s_fs_req |=> rsp_valid && !rsp.has_data && rsp.status == ST_OK)
        else $error("full scale reply wrong");
    a_type_exec: assert property (@(posedge ref_clk) disable iff (reset)
        (is_set && executing && req.attr == ATTR_VALUE_TYPE && !force_int)
        |=> $stable(value_type_ff) && rsp.status == ST_BAD_STATE)
        else $error("type written while executing");
    a_type_io: assert property (@(posedge ref_clk) disable iff (reset)
        (is_set && io_active && req.attr == ATTR_VALUE_TYPE && !force_int) |=> $stable(value_type_ff))
        else $error("type written while connected");
    a_force_int: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(polled_asm3_active) |=> value_type_ff == TYPE_INT)
        else $error("type not forced to integer");
    a_type_legal: assert property (@(posedge ref_clk) disable iff (reset)
        value_type_ff == TYPE_INT || value_type_ff == TYPE_REAL)
        else $error("illegal data type stored");
    a_override_open: assert property (@(posedge ref_clk) disable iff (reset)
        (executing && override_ff == OVR_OPEN) |=> drive_ff == FULL_OPEN)
        else $error("open override wrong");
    a_safe_value: assert property (@(posedge ref_clk) disable iff (reset)
        (!executing && fallback_ff == FB_VALUE) |=> drive_ff == $past(fallback_lvl_ff))
        else $error("safe value not driven");
    a_alarm_high: assert property (@(posedge ref_clk) disable iff (reset)
        (alarm_en_ff[0] && $signed(drive_ff) > $signed(alarm_hi_ff)) |=> flags_ff[FLAG_ALARM_HI])
        else $error("high alarm missed");
    a_warn_gate: assert property (@(posedge ref_clk) disable iff (reset)
        !warn_en_ff[0] |=> flags_ff[FLAG_WARN_LO] == 1'b0 && flags_ff[FLAG_WARN_HI] == 1'b0)
        else $error("warning set while disabled");
    a_flags_upper: assert property (@(posedge ref_clk) disable iff (reset)
        flags_ff[7:4] == 4'h0)
        else $error("status upper bits set");
endmodule : aab_bank
`default_nettype wire

// ### shared/aab_pkg.sv
// Purpose: Constants and carrier types for the actuator attribute bank.
// Assumes: Attribute identifiers are compared directly against the request attribute field.
// Notes: Type codes and unit codes are parameters of plain value.
package aab_pkg;
    localparam logic [7:0] ATTR_CLASS_REV = 8'h01;
    localparam logic [7:0] ATTR_VALUE_TYPE = 8'h03;
    localparam logic [7:0] ATTR_UNIT_SEL = 8'h04;
    localparam logic [7:0] ATTR_OVERRIDE = 8'h05;
    localparam logic [7:0] ATTR_DRIVE_LEVEL = 8'h06;
    localparam logic [7:0] ATTR_LIMIT_FLAGS = 8'h07;
    localparam logic [7:0] ATTR_ALARM_EN = 8'h08;
    localparam logic [7:0] ATTR_WARN_EN = 8'h09;
    localparam logic [7:0] ATTR_FULL_SCALE = 8'h0a;
    localparam logic [7:0] ATTR_ALARM_HI = 8'h0f;
    localparam logic [7:0] ATTR_ALARM_LO = 8'h10;
    localparam logic [7:0] ATTR_WARN_HI = 8'h12;
    localparam logic [7:0] ATTR_WARN_LO = 8'h13;
    localparam logic [7:0] ATTR_FALLBACK = 8'h15;
    localparam logic [7:0] ATTR_FALLBACK_LVL = 8'h16;
    localparam logic [7:0] SVC_GET = 8'h0e;
    localparam logic [7:0] SVC_SET = 8'h10;
    localparam logic [7:0] SVC_FULL_SCALE = 8'h32;
    localparam logic [7:0] TYPE_INT = 8'hc3;
    localparam logic [7:0] TYPE_REAL = 8'hca;
    localparam logic [15:0] UNIT_COUNTS = 16'h1001;
    localparam logic [15:0] UNIT_PERCENT = 16'h1007;
    localparam logic [15:0] REV_RESET = 16'h0001;
    localparam logic [15:0] FULL_OPEN = 16'h6000;
    localparam logic [15:0] FULL_SCALE_RESET = 16'h6000;
    localparam logic [15:0] LEVEL_ZERO = 16'h0000;
    localparam logic [15:0] INT_MAX = 16'h7fff;
    localparam logic [15:0] INT_MIN = 16'h8000;
    localparam int FLAG_ALARM_HI = 0;
    localparam int FLAG_ALARM_LO = 1;
    localparam int FLAG_WARN_HI = 2;
    localparam int FLAG_WARN_LO = 3;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    typedef enum logic [2:0] {
        OVR_NORMAL = 3'b000,
        OVR_CLOSED = 3'b001,
        OVR_OPEN = 3'b010,
        OVR_HOLD = 3'b011,
        OVR_SAFE = 3'b100
    } aab_ovr_t;
    typedef enum logic [1:0] {
        FB_CLOSED = 2'b00,
        FB_OPEN = 2'b01,
        FB_HOLD = 2'b10,
        FB_VALUE = 2'b11
    } aab_fb_t;
    typedef enum logic [2:0] {
        ST_OK = 3'b000,
        ST_BAD_ATTR = 3'b001,
        ST_READ_ONLY = 3'b010,
        ST_BAD_STATE = 3'b011,
        ST_BAD_VALUE = 3'b100,
        ST_BAD_SERVICE = 3'b101
    } aab_status_t;
    typedef struct packed {
        logic [7:0] service;
        logic [7:0] attr;
        logic [15:0] data;
    } aab_req_t;
    typedef struct packed {
        aab_status_t status;
        logic has_data;
        logic [15:0] data;
    } aab_rsp_t;
endpackage : aab_pkg

// ### src/aab_limit_cmp.sv
// Purpose: Strict signed window compare for one pair of trip points.
// Assumes: Both data types are handled as signed 16-bit words.
// Notes: Equality never raises a condition.
`timescale 1ns/10ps
`default_nettype none
module aab_limit_cmp (
    input wire logic [15:0] level,
    input wire logic [15:0] upper,
    input wire logic [15:0] lower,
    input wire logic enable,
    output logic above,
    output logic below
);
    always_comb begin
        above = enable && ($signed(level) > $signed(upper));
        below = enable && ($signed(level) < $signed(lower));
    end
endmodule : aab_limit_cmp
`default_nettype wire

// ### sim/aab_master.sv
// Purpose: Network master model issuing get, set and full-scale services.
// Assumes: One service outstanding at a time.
// Notes: Released request fields show inverted values.
`timescale 1ns/10ps
`default_nettype none
module aab_master (
    input wire logic ref_clk,
    output logic req_valid,
    output aab_pkg::aab_req_t req,
    input wire logic rsp_valid,
    input wire aab_pkg::aab_rsp_t rsp
);
    import aab_pkg::*;
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    task automatic xfer(input logic [7:0] s, input logic [7:0] a, input logic [15:0] d,
                        output aab_rsp_t r, output bit got);
        got = 1'b0;
        r = '0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{service: s, attr: a, data: d};
        @(posedge ref_clk);
        req_valid <= 1'b0;
        req <= '{service: ~s, attr: ~a, data: ~d};
        for (int i = 0; i < 4 && !got; i++) begin
            @(negedge ref_clk);
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                r = rsp;
            end
        end
    endtask : xfer
endmodule : aab_master
`default_nettype wire

// ### sim/aab_tb_top.sv
// Purpose: Self-checking bench for the actuator attribute bank.
// Assumes: Answer one cycle after the request is taken.
// Notes: Each scenario is a task that judges its own results.
`timescale 1ns/10ps
`default_nettype none
module aab_tb_top;
    import aab_pkg::*;
    logic ref_clk, reset, req_valid, rsp_valid, executing, io_active, polled_asm3_active;
    aab_req_t req;
    aab_rsp_t rsp;
    logic [15:0] control_level, drive_out;
    logic [7:0] flags_out;
    int fails, checks_done;
    aab_bank u_aab_bank (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .executing(executing), .io_active(io_active),
        .polled_asm3_active(polled_asm3_active), .control_level(control_level),
        .drive_out(drive_out), .flags_out(flags_out));
    aab_master u_aab_master (.ref_clk(ref_clk), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp));
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic run(input logic [7:0] s, input logic [7:0] a, input logic [15:0] d,
                       output aab_rsp_t r);
        bit got;
        u_aab_master.xfer(s, a, d, r, got);
        if (!got) begin
            fails++;
            results();
        end
    endtask : run
    task automatic put(input logic [7:0] a, input logic [15:0] d, input logic [2:0] st);
        aab_rsp_t r;
        run(SVC_SET, a, d, r);
        chk("set status", {13'h0000, r.status}, {13'h0000, st});
    endtask : put
    task automatic get(input logic [7:0] a, input logic [15:0] e);
        aab_rsp_t r;
        run(SVC_GET, a, 16'h0000, r);
        chk("get data", r.data, e);
    endtask : get
    task automatic settle(input logic [15:0] c);
        @(posedge ref_clk);
        control_level <= c;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        aab_rsp_t r;
        put(8'h02, 16'h0000, ST_BAD_ATTR);
        run(8'h01, ATTR_ALARM_EN, 16'h0001, r);
        chk("bad service", {13'h0000, r.status}, {13'h0000, ST_BAD_SERVICE});
        get(ATTR_CLASS_REV, REV_RESET);
        get(ATTR_VALUE_TYPE, {8'h00, TYPE_INT});
        get(ATTR_UNIT_SEL, UNIT_COUNTS);
        get(ATTR_ALARM_EN, 16'h0000);
        get(ATTR_WARN_EN, 16'h0000);
        get(ATTR_ALARM_HI, INT_MAX);
        get(ATTR_ALARM_LO, INT_MIN);
        get(ATTR_WARN_HI, INT_MAX);
        get(ATTR_WARN_LO, INT_MIN);
        get(ATTR_FALLBACK_LVL, 16'h0000);
        put(ATTR_CLASS_REV, 16'h0002, ST_READ_ONLY);
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_full_scale();
        aab_rsp_t r;
        logic [15:0] v[2] = '{16'h8000, 16'h7fff};
        for (int i = 0; i < 2; i++) begin
            run(SVC_FULL_SCALE, 8'h00, v[i], r);
            chk("fs status", {13'h0000, r.status}, 16'h0000);
            chk("fs has data", {15'h0000, r.has_data}, 16'h0000);
            get(ATTR_FULL_SCALE, v[i]);
        end
        $display("test full scale done");
    endtask : t_full_scale
    task automatic t_type();
        @(posedge ref_clk);
        executing <= 1'b1;
        put(ATTR_VALUE_TYPE, {8'h00, TYPE_REAL}, ST_BAD_STATE);
        put(ATTR_UNIT_SEL, UNIT_PERCENT, ST_BAD_STATE);
        @(posedge ref_clk);
        executing <= 1'b0;
        io_active <= 1'b1;
        put(ATTR_VALUE_TYPE, {8'h00, TYPE_REAL}, ST_READ_ONLY);
        put(ATTR_UNIT_SEL, UNIT_PERCENT, ST_OK);
        @(posedge ref_clk);
        io_active <= 1'b0;
        put(ATTR_VALUE_TYPE, 16'h0055, ST_BAD_VALUE);
        put(ATTR_VALUE_TYPE, {8'h00, TYPE_REAL}, ST_OK);
        get(ATTR_VALUE_TYPE, {8'h00, TYPE_REAL});
        @(posedge ref_clk);
        polled_asm3_active <= 1'b1;
        repeat (2) @(posedge ref_clk);
        polled_asm3_active <= 1'b0;
        get(ATTR_VALUE_TYPE, {8'h00, TYPE_INT});
        get(ATTR_UNIT_SEL, UNIT_PERCENT);
        $display("test type done");
    endtask : t_type
    task automatic t_override();
        logic [15:0] e[3] = '{16'h0000, FULL_OPEN, FULL_OPEN};
        logic [15:0] code[3] = '{16'h0001, 16'h0002, 16'h0004};
        @(posedge ref_clk);
        executing <= 1'b1;
        put(ATTR_FALLBACK, 16'h0001, ST_OK);
        settle(16'h1234);
        chk("drive", drive_out, 16'h1234);
        put(ATTR_OVERRIDE, 16'h0003, ST_OK);
        settle(16'h0100);
        chk("drive", drive_out, 16'h1234);
        for (int i = 0; i < 3; i++) begin
            put(ATTR_OVERRIDE, code[i], ST_OK);
            settle(16'h0100);
            chk("drive", drive_out, e[i]);
        end
        put(ATTR_OVERRIDE, 16'h0005, ST_BAD_VALUE);
        get(ATTR_OVERRIDE, 16'h0004);
        get(ATTR_DRIVE_LEVEL, FULL_OPEN);
        put(ATTR_OVERRIDE, 16'h0000, ST_OK);
        settle(16'h0200);
        chk("drive", drive_out, 16'h0200);
        $display("test override done");
    endtask : t_override
    task automatic t_fallback();
        logic [15:0] e[4] = '{16'h0000, FULL_OPEN, 16'h0200, 16'h0abc};
        put(ATTR_FALLBACK_LVL, 16'h0abc, ST_OK);
        @(posedge ref_clk);
        executing <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            put(ATTR_FALLBACK, i[15:0], ST_OK);
            settle(16'h0300);
            chk("safe drive", drive_out, e[i]);
        end
        get(ATTR_DRIVE_LEVEL, 16'h0abc);
        put(ATTR_FALLBACK, 16'h0004, ST_BAD_VALUE);
        get(ATTR_FALLBACK, 16'h0003);
        @(posedge ref_clk);
        executing <= 1'b1;
        $display("test fallback done");
    endtask : t_fallback
    task automatic t_limits();
        logic [15:0] c[6] = '{16'h0100, 16'h0101, 16'h0080, 16'hfff0, 16'hffef, 16'h0000};
        logic [7:0] e[6] = '{8'h04, 8'h05, 8'h00, 8'h08, 8'h0a, 8'h00};
        put(ATTR_ALARM_EN, 16'h0001, ST_OK);
        put(ATTR_WARN_EN, 16'h0001, ST_OK);
        put(ATTR_ALARM_HI, 16'h0100, ST_OK);
        put(ATTR_ALARM_LO, 16'hfff0, ST_OK);
        put(ATTR_WARN_HI, 16'h0080, ST_OK);
        put(ATTR_WARN_LO, 16'h0000, ST_OK);
        for (int i = 0; i < 6; i++) begin
            settle(c[i]);
            chk("flags", {8'h00, flags_out}, {8'h00, e[i]});
        end
        put(ATTR_WARN_EN, 16'h0000, ST_OK);
        settle(16'h0101);
        chk("flags", {8'h00, flags_out}, 16'h0001);
        get(ATTR_LIMIT_FLAGS, 16'h0001);
        put(ATTR_ALARM_EN, 16'h0000, ST_OK);
        settle(16'h0101);
        chk("flags", {8'h00, flags_out}, 16'h0000);
        $display("test limits done");
    endtask : t_limits
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        reset = 1'b1;
        executing = 1'b0;
        io_active = 1'b0;
        polled_asm3_active = 1'b0;
        control_level = 16'h0000;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_defaults();
        t_full_scale();
        t_type();
        t_override();
        t_fallback();
        t_limits();
        results();
    end
endmodule : aab_tb_top
`default_nettype wire
